// ==== rtl/usx_top.sv ====
// Serial transmit and receive path, no parity or stop bit checks on receive, with a plain register port
`timescale 1ns/1ps
module usx_top
  import usx_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata_r,
  // Interrupt service
  input  wire logic       tx_done_serviced,
  output logic            irq_buf_empty_r,
  output logic            irq_tx_done_r,
  // Serial pins
  output logic            txd_out_r,
  output logic            txd_oe_r,
  input  wire logic       rxd_in,
  output logic            rxd_taken_r,
  input  wire logic       ext_serial_clock_pin,
  output logic            ext_clk_taken_r
);

  // ********************************************************
  // Functions
  // ********************************************************
  function automatic logic [3:0] data_bits(input logic [2:0] code);
    unique case (code)
      3'h0:    data_bits = 4'h5;
      3'h1:    data_bits = 4'h6;
      3'h2:    data_bits = 4'h7;
      3'h7:    data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction

  function automatic logic [8:0] size_mask(input logic [2:0] code);
    logic [3:0] n;
    n = data_bits(code);
    size_mask = 9'h1ff >> (4'h9 - n);
  endfunction

  // ********************************************************
  // Registers
  // ********************************************************
  logic [7:0]  ctrl_b_r;
  logic [7:0]  fmt_r;
  logic [11:0] baud_divisor_r;
  logic        double_speed_bit_r;
  usx_fmt_s    fmt;
  logic        wr_data, wr_ctrl_a, rd_data;
  logic        transmitter_on, receiver_on;

  assign fmt.sync           = fmt_r[F_SYNC];
  assign fmt.par_on         = fmt_r[F_PAR_ON];
  assign fmt.par_odd        = fmt_r[F_PAR_ODD];
  assign fmt.two_stop       = fmt_r[F_TWO_STOP];
  assign fmt.char_size_code = {ctrl_b_r[B_SIZE2], fmt_r[F_SIZE_HI:F_SIZE_LO]};
  assign fmt.pol            = fmt_r[F_POL];
  assign wr_data        = reg_wr && reg_addr == ADDR_DATA;
  assign wr_ctrl_a      = reg_wr && reg_addr == ADDR_CTRL_A;
  assign rd_data        = reg_rd && reg_addr == ADDR_DATA;
  assign transmitter_on = ctrl_b_r[B_TX_ON];
  assign receiver_on    = ctrl_b_r[B_RX_ON];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_b_r           <= RST_CTRL_B;
      fmt_r              <= RST_FMT;
      baud_divisor_r     <= RST_BAUD;
      double_speed_bit_r <= 1'b0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CTRL_A: double_speed_bit_r <= reg_wdata[A_DOUBLE];
        ADDR_CTRL_B: ctrl_b_r <= reg_wdata;
        ADDR_FMT:    fmt_r <= reg_wdata;
        ADDR_BAUD_L: baud_divisor_r[7:0] <= reg_wdata;
        ADDR_BAUD_H: baud_divisor_r[11:8] <= reg_wdata[3:0];
        default:     ;
      endcase
    end
  end

  // ********************************************************
  // Pin synchronisers and clock edges
  // ********************************************************
  logic [1:0] rxd_sync_r, xck_sync_r;
  logic       xck_prev_r;
  logic       xck_rise, xck_fall, tx_ext_edge, rx_ext_edge, rxd;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rxd_sync_r <= 2'h3;
      xck_sync_r <= 2'h0;
      xck_prev_r <= 1'b0;
    end else begin
      rxd_sync_r <= {rxd_sync_r[0], rxd_in};
      xck_sync_r <= {xck_sync_r[0], ext_serial_clock_pin};
      xck_prev_r <= xck_sync_r[1];
    end
  end

  assign rxd         = rxd_sync_r[1];
  assign xck_rise    = xck_sync_r[1] && !xck_prev_r;
  assign xck_fall    = !xck_sync_r[1] && xck_prev_r;
  assign tx_ext_edge = fmt.pol ? xck_fall : xck_rise;
  assign rx_ext_edge = fmt.pol ? xck_rise : xck_fall;

  // ********************************************************
  // Baud divider
  // ********************************************************
  logic [11:0] baud_cnt_r;
  logic        sub_tick;
  logic [3:0]  osr_last;

  assign sub_tick = baud_cnt_r == 12'h000;
  assign osr_last = double_speed_bit_r ? OSR_DOUBLE : OSR_NORMAL;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      baud_cnt_r <= RST_BAUD;
    end else if (sub_tick) begin
      baud_cnt_r <= baud_divisor_r;
    end else begin
      baud_cnt_r <= baud_cnt_r - 12'h001;
    end
  end

  // ********************************************************
  // Transmit buffer and flags
  // ********************************************************
  logic [8:0] tx_buf_r;
  logic       tx_full_r, tx_done_r;
  logic       tx_load, frame_end, done_set;
  usx_tx_e    tx_st_r;
  logic       tx_step;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_buf_r  <= 9'h000;
      tx_full_r <= 1'b0;
    end else if (wr_data) begin
      tx_buf_r  <= {ctrl_b_r[B_TX_NINTH], reg_wdata}
                   & size_mask(fmt.char_size_code);
      tx_full_r <= 1'b1;
    end else if (tx_load) begin
      tx_full_r <= 1'b0;
    end
  end

  assign done_set = frame_end && !tx_full_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_done_r <= 1'b0;
    end else if (done_set) begin
      tx_done_r <= 1'b1;
    end else if (tx_done_serviced
                 || (wr_ctrl_a && reg_wdata[A_TX_DONE])) begin
      tx_done_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_buf_empty_r <= 1'b0;
      irq_tx_done_r   <= 1'b0;
    end else begin
      irq_buf_empty_r <= ctrl_b_r[B_EMPTY_IE] && !tx_full_r;
      irq_tx_done_r   <= ctrl_b_r[B_DONE_IE] && tx_done_r;
    end
  end

  // ********************************************************
  // Transmit shifter
  // ********************************************************
  logic [8:0] tx_sh_r;
  logic [3:0] tx_cnt_r, tx_sub_r;
  logic       tx_par_r;

  assign tx_step = fmt.sync ? tx_ext_edge
                 : (sub_tick && tx_sub_r == osr_last);
  assign frame_end = tx_step && ((tx_st_r == TX_STOP2)
                   || (tx_st_r == TX_STOP1 && !fmt.two_stop));
  assign tx_load = tx_full_r && ((tx_st_r == TX_IDLE && transmitter_on)
                   || frame_end);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_sub_r <= 4'h0;
    end else if (tx_load || tx_sub_r == osr_last && sub_tick) begin
      tx_sub_r <= 4'h0;
    end else if (sub_tick) begin
      tx_sub_r <= tx_sub_r + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_r   <= TX_IDLE;
      txd_out_r <= 1'b1;
      tx_sh_r   <= 9'h000;
      tx_cnt_r  <= 4'h0;
      tx_par_r  <= 1'b0;
    end else if (tx_load) begin
      tx_st_r   <= TX_START;
      txd_out_r <= 1'b0;
      tx_sh_r   <= tx_buf_r;
      tx_par_r  <= (^tx_buf_r) ^ fmt.par_odd;
    end else if (tx_step) begin
      unique case (tx_st_r)
        TX_IDLE: txd_out_r <= 1'b1;
        TX_START: begin
          tx_st_r   <= TX_DATA;
          txd_out_r <= tx_sh_r[0];
          tx_sh_r   <= tx_sh_r >> 1;
          tx_cnt_r  <= data_bits(fmt.char_size_code);
        end
        TX_DATA: begin
          if (tx_cnt_r == 4'h1 && fmt.par_on) begin
            tx_st_r   <= TX_PAR;
            txd_out_r <= tx_par_r;
          end else if (tx_cnt_r == 4'h1) begin
            tx_st_r   <= TX_STOP1;
            txd_out_r <= 1'b1;
          end else begin
            txd_out_r <= tx_sh_r[0];
            tx_sh_r   <= tx_sh_r >> 1;
            tx_cnt_r  <= tx_cnt_r - 4'h1;
          end
        end
        TX_PAR: begin
          tx_st_r   <= TX_STOP1;
          txd_out_r <= 1'b1;
        end
        TX_STOP1: tx_st_r <= fmt.two_stop ? TX_STOP2 : TX_IDLE;
        TX_STOP2: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txd_oe_r        <= 1'b0;
      ext_clk_taken_r <= 1'b0;
      rxd_taken_r     <= 1'b0;
    end else begin
      txd_oe_r        <= transmitter_on || tx_st_r != TX_IDLE
                         || tx_load;
      ext_clk_taken_r <= fmt.sync && (transmitter_on || receiver_on
                         || tx_st_r != TX_IDLE);
      rxd_taken_r     <= receiver_on;
    end
  end

  // ********************************************************
  // Receive shifter and buffer
  // ********************************************************
  usx_rx_e    rx_st_r;
  logic [8:0] rx_sh_r, rx_data_r;
  logic [3:0] rx_cnt_r, rx_sub_r, rx_target;
  logic       rx_ready_r, rx_samp, rx_done;

  assign rx_target = rx_st_r == RX_START ? (osr_last >> 1) : osr_last;
  assign rx_samp   = fmt.sync ? rx_ext_edge
                   : (sub_tick && rx_sub_r == rx_target);
  assign rx_done   = receiver_on && rx_samp && rx_st_r == RX_STOP;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_sub_r <= 4'h0;
    end else if (rx_st_r == RX_IDLE || rx_samp) begin
      rx_sub_r <= 4'h0;
    end else if (sub_tick) begin
      rx_sub_r <= rx_sub_r + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_r  <= RX_IDLE;
      rx_sh_r  <= 9'h000;
      rx_cnt_r <= 4'h0;
    end else if (!receiver_on) begin
      rx_st_r <= RX_IDLE;
    end else begin
      unique case (rx_st_r)
        RX_IDLE: begin
          rx_cnt_r <= data_bits(fmt.char_size_code);
          rx_sh_r  <= 9'h000;
          if (!rxd && !fmt.sync) begin
            rx_st_r <= RX_START;
          end else if (!rxd && rx_samp) begin
            rx_st_r <= RX_DATA;
          end
        end
        RX_START: if (rx_samp) begin
          rx_st_r <= rxd ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_samp) begin
          rx_sh_r  <= {rxd, rx_sh_r[8:1]};
          rx_cnt_r <= rx_cnt_r - 4'h1;
          if (rx_cnt_r == 4'h1) begin
            rx_st_r <= fmt.par_on ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: if (rx_samp) begin
          rx_st_r <= RX_STOP;
        end
        RX_STOP: if (rx_samp) begin
          rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_data_r  <= 9'h000;
      rx_ready_r <= 1'b0;
    end else if (!receiver_on) begin
      rx_ready_r <= 1'b0;
    end else if (rx_done) begin
      rx_data_r  <= (rx_sh_r >> (4'h9 - data_bits(fmt.char_size_code)))
                    & size_mask(fmt.char_size_code);
      rx_ready_r <= 1'b1;
    end else if (rd_data) begin
      rx_ready_r <= 1'b0;
    end
  end

  // ********************************************************
  // Read data
  // ********************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_DATA:   reg_rdata_r <= rx_data_r[7:0];
        ADDR_CTRL_A: reg_rdata_r <= {rx_ready_r, tx_done_r, !tx_full_r,
                                     3'h0, double_speed_bit_r, 1'b0};
        ADDR_CTRL_B: reg_rdata_r <= {ctrl_b_r[7:2], rx_data_r[8],
                                     ctrl_b_r[0]};
        ADDR_FMT:    reg_rdata_r <= fmt_r;
        ADDR_BAUD_L: reg_rdata_r <= baud_divisor_r[7:0];
        ADDR_BAUD_H: reg_rdata_r <= {4'h0, baud_divisor_r[11:8]};
        default:     reg_rdata_r <= 8'h00;
      endcase
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence tx_idle_ready_s;
    tx_st_r == TX_IDLE && tx_full_r && transmitter_on;
  endsequence

  sequence frame_started_s;
    tx_st_r == TX_START && !txd_out_r && !tx_full_r;
  endsequence

  idle_line_high_a: assert property (
    tx_st_r == TX_IDLE |-> txd_out_r)
    else $error("Idle serial output not high");
  buffer_load_a: assert property (
    (tx_idle_ready_s and !wr_data) |=> frame_started_s)
    else $error("Buffered word not moved to shifter");
  write_fills_a: assert property (
    wr_data |=> tx_full_r ##1 !irq_buf_empty_r)
    else $error("Data write did not clear empty flag");
  empty_request_a: assert property (
    ctrl_b_r[B_EMPTY_IE] && !tx_full_r |=> irq_buf_empty_r)
    else $error("Empty request missing");
  done_rise_a: assert property (
    $rose(tx_done_r) |-> !$past(tx_full_r) && tx_st_r == TX_IDLE)
    else $error("Done flag set with frame pending");
  done_clear_a: assert property (
    tx_done_serviced && !done_set |=> !tx_done_r)
    else $error("Done flag not cleared on service");
  parity_bit_a: assert property (
    $rose(tx_st_r == TX_PAR) |-> txd_out_r == tx_par_r)
    else $error("Parity bit wrong on line");
  pin_release_a: assert property (
    (!transmitter_on && tx_st_r == TX_IDLE && !tx_full_r) [*2] |-> !txd_oe_r)
    else $error("Serial pin held after disable");
  rx_upper_zero_a: assert property (
    rx_done && fmt.char_size_code < 3'h3 |=> rx_data_r[8:7] == 2'h0)
    else $error("Unused receive bits not zero");

endmodule

// ==== rtl/usx_pkg.sv ====
// Package of constants and types for the serial transmit and receive path
package usx_pkg;

  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [2:0] ADDR_DATA   = 3'h0;
  localparam logic [2:0] ADDR_CTRL_A = 3'h1;
  localparam logic [2:0] ADDR_CTRL_B = 3'h2;
  localparam logic [2:0] ADDR_FMT    = 3'h3;
  localparam logic [2:0] ADDR_BAUD_L = 3'h4;
  localparam logic [2:0] ADDR_BAUD_H = 3'h5;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int A_RX_READY  = 7;
  localparam int A_TX_DONE   = 6;
  localparam int A_TX_EMPTY  = 5;
  localparam int A_DOUBLE    = 1;
  localparam int B_DONE_IE   = 6;
  localparam int B_EMPTY_IE  = 5;
  localparam int B_RX_ON     = 4;
  localparam int B_TX_ON     = 3;
  localparam int B_SIZE2     = 2;
  localparam int B_RX_NINTH  = 1;
  localparam int B_TX_NINTH  = 0;
  localparam int F_SYNC      = 6;
  localparam int F_PAR_ON    = 5;
  localparam int F_PAR_ODD   = 4;
  localparam int F_TWO_STOP  = 3;
  localparam int F_SIZE_HI   = 2;
  localparam int F_SIZE_LO   = 1;
  localparam int F_POL       = 0;

  // ********************************************************
  // Reset values and timing counts
  // ********************************************************
  localparam logic [7:0]  RST_CTRL_B = 8'h00;
  localparam logic [7:0]  RST_FMT    = 8'h06;
  localparam logic [11:0] RST_BAUD   = 12'h000;
  localparam logic [3:0]  OSR_NORMAL = 4'hf;
  localparam logic [3:0]  OSR_DOUBLE = 4'h7;
  localparam logic [2:0]  SIZE_NINE  = 3'h7;

  // ********************************************************
  // Types
  // ********************************************************
  typedef struct packed {
    logic       sync;
    logic       par_on;
    logic       par_odd;
    logic       two_stop;
    logic [2:0] char_size_code;
    logic       pol;
  } usx_fmt_s;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2
  } usx_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } usx_rx_e;

endpackage

// ==== sim/usx_peer.sv ====
// Remote serial peer: captures sent frames and sends frames
`timescale 1ns/1ps
module usx_peer (
  // Serial pins
  input  wire logic txd_out_r,
  input  wire logic txd_oe_r,
  output logic      rxd,
  output logic      sclk
);
  // ********
  // Capture
  // ********
  logic        line;
  logic [12:0] v;
  logic [12:0] got[$];
  int          nb = 10;
  int          bt = 800;
  // Pull-up while the pin is released
  assign line = txd_oe_r ? txd_out_r : 1'b1;
  initial begin
    rxd  = 1'b1;
    sclk = 1'b0;
  end
  // Start on the falling edge, sample mid bit up to the first stop
  always begin
    @(negedge line);
    v = 13'h0000;
    #(bt / 2);
    for (int i = 0; i < nb; i++) begin
      if (i > 0)
        #(bt);
      v[i] = line;
    end
    got.push_back(v);
  end
  // ********
  // Sending
  // ********
  // Clock stands still outside frames; line idles high
  task automatic send(input logic [12:0] f, input int n, input int t,
                      input bit s);
    for (int i = 0; i < n; i++) begin
      if (s) begin
        sclk = 1'b1;
        rxd  = f[i];
        #(t);
        sclk = 1'b0;
        #(t);
      end else begin
        rxd = f[i];
        #(t);
      end
    end
    rxd = 1'b1;
  endtask
endmodule

// ==== sim/usart_transmit_receive_path_tb.sv ====
// Self-checking bench of the serial transmit and receive path
`timescale 1ns/1ps
module usart_transmit_receive_path_tb
  import usx_pkg::*;
;
  // ********
  // Signals
  // ********
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        tx_done_serviced = 1'b0;
  logic [7:0]  reg_rdata_r;
  logic        irq_buf_empty_r;
  logic        irq_tx_done_r;
  logic        txd_out_r;
  logic        txd_oe_r;
  logic        rxd_in;
  logic        rxd_taken_r;
  logic        ext_serial_clock_pin;
  logic        ext_clk_taken_r;
  logic [7:0]  rv;
  logic [7:0]  div;
  logic [12:0] f;
  logic [8:0]  d;
  logic [2:0]  code;
  logic        pon, odd, ts, dbl, h;
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n, bt, c;
  always #25 clock = ~clock;
  usx_top u_dut (
    .clock(clock),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r),
    .tx_done_serviced(tx_done_serviced),
    .irq_buf_empty_r(irq_buf_empty_r),
    .irq_tx_done_r(irq_tx_done_r),
    .txd_out_r(txd_out_r),
    .txd_oe_r(txd_oe_r),
    .rxd_in(rxd_in),
    .rxd_taken_r(rxd_taken_r),
    .ext_serial_clock_pin(ext_serial_clock_pin),
    .ext_clk_taken_r(ext_clk_taken_r)
  );
  usx_peer u_peer (
    .txd_out_r(txd_out_r),
    .txd_oe_r(txd_oe_r),
    .rxd(rxd_in),
    .sclk(ext_serial_clock_pin)
  );
  // ********
  // Tasks
  // ********
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= w;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata_r;
  endtask
  task automatic chk(input string s, input logic [12:0] e,
                     input logic [12:0] o);
    checked++;
    if (o !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", s, e, o);
    end
  endtask
  task automatic wait_a(input int b);
    for (int i = 0; i < 400; i++) begin
      rd(ADDR_CTRL_A);
      if (rv[b] === 1'b1)
        break;
    end
    if (rv[b] !== 1'b1)
      n_fail++;
  endtask
  task automatic wait_got;
    for (int i = 0; i < 3000 && u_peer.got.size() == 0; i++)
      @(posedge clock);
    f = (u_peer.got.size() > 0) ? u_peer.got.pop_front() : 13'h1fff;
  endtask
  task automatic setup(input logic [2:0] cd, input logic sy,
                       input logic [7:0] b);
    wr(ADDR_FMT, {1'b0, sy, pon, odd, ts, cd[1:0], 1'b0});
    wr(ADDR_CTRL_A, {6'h00, dbl, 1'b0});
    wr(ADDR_BAUD_L, div);
    wr(ADDR_BAUD_H, 8'h00);
    wr(ADDR_CTRL_B, b | {5'h00, cd[2], 2'h0});
    n = (cd == SIZE_NINE) ? 9 : 5 + int'(cd);
    bt = (int'(div) + 1) * (dbl ? 400 : 800);
    u_peer.nb = n + 2 + int'(pon);
    u_peer.bt = bt;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic pick(input int k);
    code = (k % 5 == 4) ? SIZE_NINE : 3'(k % 5);
    {pon, odd, ts, dbl} = 4'($urandom);
    div = 8'($urandom % 2);
    d = (k == 0) ? 9'h1ff : 9'($urandom);
  endtask
  function automatic logic [12:0] frame(input logic [8:0] x, input int w,
                                        input logic p, input logic o);
    logic [12:0] r;
    r = {3'h0, x & 9'((1 << w) - 1), 1'b0};
    if (p)
      r[w + 1] = ^r ^ o;
    r[w + 1 + int'(p)] = 1'b1;
    return r;
  endfunction
  task automatic print_verdict;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      print_verdict();
    end
  end
  // ********
  // Scenarios
  // ********
  initial begin
    c = $urandom(32'h29f1);
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    rd(ADDR_CTRL_A);
    chk("ctrl_a", 13'h020, rv);
    rd(ADDR_FMT);
    chk("fmt", RST_FMT, rv);
    rd(3'h6);
    chk("unmapped", 13'h000, rv);
    chk("oe_rst", 13'h0, txd_oe_r);
    for (int k = 0; k < 10; k++) begin
      pick(k);
      setup(code, 1'b0, {7'h04, d[8]});
      wr(ADDR_DATA, d[7:0]);
      repeat (4) @(posedge clock);
      #1;
      chk("tx_oe", 13'h1, txd_oe_r);
      wait_got();
      chk("frame", frame(d, n, pon, odd), f);
      wait_a(A_TX_DONE);
      chk("done_empty", 13'h060, rv & 8'h60);
      wr(ADDR_CTRL_A, {1'b0, 1'b1, 4'h0, dbl, 1'b0});
      rd(ADDR_CTRL_A);
      chk("done_clr", 13'h0, rv[A_TX_DONE]);
    end
    setup(3'h3, 1'b0, 8'h68);
    wr(ADDR_DATA, d[7:0]);
    wr(ADDR_DATA, ~d[7:0]);
    rd(ADDR_CTRL_A);
    chk("buf_full", 13'h0, rv[A_TX_EMPTY]);
    chk("irq_e_off", 13'h0, irq_buf_empty_r);
    wait_got();
    chk("frame_a", frame({1'b0, d[7:0]}, 8, pon, odd), f);
    #(bt * 2);
    rd(ADDR_CTRL_A);
    chk("no_done", 13'h0, rv[A_TX_DONE]);
    chk("irq_e_on", 13'h1, irq_buf_empty_r);
    wait_got();
    chk("frame_b", frame({1'b0, ~d[7:0]}, 8, pon, odd), f);
    wait_a(A_TX_DONE);
    repeat (2) @(posedge clock);
    #1;
    chk("irq_done", 13'h1, irq_tx_done_r);
    @(posedge clock);
    tx_done_serviced <= 1'b1;
    @(posedge clock);
    tx_done_serviced <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk("irq_done_clr", 13'h0, irq_tx_done_r);
    wr(ADDR_DATA, d[7:0]);
    wr(ADDR_CTRL_B, 8'h60);
    repeat (8) @(posedge clock);
    #1;
    chk("oe_hold", 13'h1, txd_oe_r);
    wait_got();
    chk("frame_c", frame({1'b0, d[7:0]}, 8, pon, odd), f);
    wait_a(A_TX_DONE);
    repeat (3) @(posedge clock);
    #1;
    chk("oe_free", 13'h0, txd_oe_r);
    for (int k = 0; k < 5; k++) begin
      pick(k + 1);
      setup(code, 1'b0, 8'h10);
      chk("rx_pin", 13'h1, rxd_taken_r);
      f = frame(d, n, pon, odd) | (13'h1 << (n + 2 + int'(pon)));
      u_peer.send(f, n + 3 + int'(pon), bt, 1'b0);
      wait_a(A_RX_READY);
      rd(ADDR_CTRL_B);
      h = rv[B_RX_NINTH];
      rd(ADDR_DATA);
      chk("rx_data", 8'(d & 9'((1 << n) - 1)), rv);
      if (n == 9)
        chk("rx_ninth", d[8], h);
    end
    u_peer.send(13'h0002, 2, bt / 4, 1'b0);
    #(bt * 14);
    rd(ADDR_CTRL_A);
    chk("false_start", 13'h0, rv[A_RX_READY]);
    setup(3'h3, 1'b1, 8'h10);
    chk("xck_pin", 13'h1, ext_clk_taken_r);
    u_peer.send(frame(d, 8, pon, odd), 10 + int'(pon), 200, 1'b1);
    wait_a(A_RX_READY);
    rd(ADDR_DATA);
    chk("sync_rx", d[7:0], rv);
    wr(ADDR_FMT, {1'b0, 1'b1, pon, odd, ts, 2'h3, 1'b1});
    wr(ADDR_CTRL_B, 8'h18);
    u_peer.bt = 400;
    wr(ADDR_DATA, d[7:0]);
    #(125);
    u_peer.send(13'h1fff, 12, 200, 1'b1);
    wait_got();
    chk("sync_tx", frame(d, 8, pon, odd), f);
    print_verdict();
  end
endmodule
